// File: rtl/pvc_pkg.sv
// pvc_pkg: shared offsets, bit positions, reset values and encodings
package pvc_pkg;

	// ------------------------------------------------------------
	// register offsets (5-bit management address space)
	// ------------------------------------------------------------
	localparam logic [4:0]  OFF_OSC_CTL     = 5'h11;
	localparam logic [4:0]  OFF_TXAMP_CTL   = 5'h13;
	localparam logic [4:0]  OFF_SYMERR_CNT  = 5'h15;
	localparam logic [4:0]  OFF_STRAP_WAKE  = 5'h16;
	localparam logic [4:0]  OFF_IRQ_STATUS  = 5'h1a;
	localparam logic [4:0]  OFF_IRQ_MASK    = 5'h1b;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int          OSC_SLOW_BIT    = 5;
	localparam int          TX_REDUCED_BIT  = 4;
	localparam int          WAKE_EN_BIT     = 15;
	localparam int          BCAST_OVR_BIT   = 9;
	localparam int          STRAP_RO_BIT    = 10;

	// ------------------------------------------------------------
	// reset values and masks
	// ------------------------------------------------------------
	localparam logic [15:0] RST_OSC_CTL     = 16'h0000;
	localparam logic [15:0] RST_TXAMP_CTL   = 16'h0000;
	localparam logic [15:0] RST_STRAP_WAKE  = 16'h0000;
	localparam logic [15:0] RST_SYMERR_CNT  = 16'h0000;
	localparam logic [15:0] STRAP_WAKE_WMSK = 16'hfbff;
	localparam logic [15:0] SYMERR_MAX      = 16'hffff;
	localparam logic [15:0] RDATA_NONE      = 16'h0000;

	// ------------------------------------------------------------
	// interrupt status / mask layout
	// ------------------------------------------------------------
	localparam int          IRQ_W           = 2;
	localparam int          IRQ_CNT_BIT     = 0;
	localparam int          IRQ_WAKE_BIT    = 1;
	localparam logic [1:0]  RST_IRQ         = 2'h0;

	// ------------------------------------------------------------
	// wake pin routing codes and startup phase
	// ------------------------------------------------------------
	localparam logic [1:0]  WAKE_ROUTE_A    = 2'h0;
	localparam logic [1:0]  WAKE_ROUTE_B    = 2'h1;
	localparam logic [1:0]  WAKE_ROUTE_BOTH = 2'h2;

	typedef enum logic [1:0] {
		PH_LOAD = 2'b01,
		PH_RUN  = 2'b10
	} pvc_phase_e;

endpackage : pvc_pkg

// File: rtl/pvc_symerr_count.sv
// pvc_symerr_count: saturating per-frame symbol-error counter, clear on read
module pvc_symerr_count
	import pvc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        sym_err,
	input  wire logic        frame_end,
	input  wire logic        clear,
	output logic [15:0]      count,
	output logic             counted
);
	typedef struct packed {
		logic        in_err;
		logic [15:0] cnt;
		logic        hit;
	} pvc_cnt_s;

	pvc_cnt_s s_q;
	pvc_cnt_s s_d;
	logic     inc;

	// one count per errored frame, held at all ones
	always_comb
	begin
		s_d = s_q;
		inc = frame_end && (s_q.in_err || sym_err);
		s_d.hit = inc;
		if (frame_end)
			s_d.in_err = 1'b0;
		else if (sym_err)
			s_d.in_err = 1'b1;
		// a frame closing in the read cycle is kept, not lost
		if (clear)
			s_d.cnt = inc ? 16'h0001 : RST_SYMERR_CNT;
		else if (inc && s_q.cnt != SYMERR_MAX)
			s_d.cnt = s_q.cnt + 16'h0001;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s_q <= '{in_err: 1'b0, cnt: RST_SYMERR_CNT, hit: 1'b0};
		else
			s_q <= s_d;
	end

	assign count   = s_q.cnt;
	assign counted = s_q.hit;

endmodule : pvc_symerr_count

// File: rtl/pvc_wake_route.sv
// pvc_wake_route: gates and steers the wake request onto two pins
module pvc_wake_route
	import pvc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        enable,
	input  wire logic [1:0]  route,
	input  wire logic        pending,
	output logic             pin_a,
	output logic             pin_b
);
	typedef struct packed {
		logic a;
		logic b;
	} pvc_pins_s;

	pvc_pins_s s_q;
	pvc_pins_s s_d;
	logic      req;

	// route code selects pin a, pin b, both or neither
	always_comb
	begin
		req = enable && pending;
		s_d.a = req && (route == WAKE_ROUTE_A || route == WAKE_ROUTE_BOTH);
		s_d.b = req && (route == WAKE_ROUTE_B || route == WAKE_ROUTE_BOTH);
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s_q <= '{a: 1'b0, b: 1'b0};
		else
			s_q <= s_d;
	end

	assign pin_a = s_q.a;
	assign pin_b = s_q.b;

endmodule : pvc_wake_route

// File: rtl/pvc_regs.sv
// pvc_regs: vendor control registers for oscillator, tx amplitude, errors, wake

// Functional notes
// - Setting the slow-oscillator bit switches the clock source from crystal_input to the slow oscillator.
// - The slow-oscillator bit also powers down the analog front end and resets to zero.
// - With the amplitude mode bit at one the transmitter uses reduced 1.75V 10Base-Te levels.
// - With the amplitude mode bit at zero, its reset value, the transmitter uses full 2.5V levels.
// - A 16-bit read-only counter of errored frames resets to zero and clears when read.
// - The wake enable bit gates the wake output and with the route code picks the two pins.
// - The wake enable bit resets to zero and loads the wake_enable_strap pin on the first edge after reset release.
// - The broadcast_disable override bit is read-write, resets to zero and is ORed with the strap.
// - While the override is set address 0 is answered only when it is the own address.
// - Bit 10 of the strap register always reads zero, other reserved bits are plain storage.
module pvc_regs
	import pvc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	input  wire logic        rx_symbol_error,
	input  wire logic        rx_frame_end,
	input  wire logic        power_wake_event,
	input  wire logic [1:0]  wake_route,
	input  wire logic        wake_enable_strap,
	input  wire logic        broadcast_strap,
	input  wire logic [4:0]  own_phy_addr,
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic        mgmt_addr_valid,
	output logic             mgmt_addr_hit,
	output logic             broadcast_disable,
	output logic             slow_osc_select,
	output logic             analog_frontend_pdn,
	output logic             tx_reduced_amp,
	output logic             wake_pin_a,
	output logic             wake_pin_b,
	output logic             irq
);
	import pvc_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		pvc_phase_e          phase;
		logic [15:0]         osc_ctl;
		logic [15:0]         txamp_ctl;
		logic [15:0]         strap_wake;
		logic [IRQ_W-1:0]    irq_stat;
		logic [IRQ_W-1:0]    irq_mask;
		logic                irq;
		logic [15:0]         rdata;
		logic                hit;
		logic                bcast_off;
	} pvc_state_s;

	pvc_state_s          s_q;
	pvc_state_s          s_d;

	logic [15:0]         err_count;
	logic                err_counted;
	logic                cnt_clear;
	logic                wr_stat;
	logic [IRQ_W-1:0]    irq_event;
	logic [IRQ_W-1:0]    stat_next;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------

	// one address compare, shared by the counter-clear and status-write strobe decodes
	function automatic logic addr_is(input logic [4:0] addr, input logic [4:0] off);
		addr_is = (addr == off);
	endfunction : addr_is

	// a read of the counter offset empties it in the same cycle
	assign cnt_clear = reg_rd && addr_is(reg_addr, OFF_SYMERR_CNT);
	assign wr_stat   = reg_wr && addr_is(reg_addr, OFF_IRQ_STATUS);

	// ------------------------------------------------------------
	// error counter
	// ------------------------------------------------------------

	// frame tracking lives in the counter so the one-per-frame rule stays local
	pvc_symerr_count u_cnt (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.sym_err   (rx_symbol_error),
		.frame_end (rx_frame_end),
		.clear     (cnt_clear),
		.count     (err_count),
		.counted   (err_counted)
	);

	// ------------------------------------------------------------
	// sticky status, write one to clear
	// ------------------------------------------------------------
	assign irq_event[IRQ_CNT_BIT]  = err_counted;
	assign irq_event[IRQ_WAKE_BIT] = power_wake_event;

	// an event in the clearing cycle wins so it is never dropped
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W; gi++)
		begin : g_stat
			assign stat_next[gi] = irq_event[gi] |
				(s_q.irq_stat[gi] & ~(wr_stat & reg_wdata[gi]));
		end
	endgenerate

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;

		// strap is caught on the first edge after reset release
		case (s_q.phase)
			PH_LOAD:
			begin
				s_d.strap_wake[WAKE_EN_BIT] = wake_enable_strap;
				s_d.phase = PH_RUN;
			end
			PH_RUN:
			begin
				s_d.phase = PH_RUN;
			end
			default:
			begin
				s_d.phase = PH_LOAD;
			end
		endcase

		// register writes; a write in the load cycle overrides the strap
		if (reg_wr)
		begin
			case (reg_addr)
				OFF_OSC_CTL:
				begin
					s_d.osc_ctl = reg_wdata;
				end
				OFF_TXAMP_CTL:
				begin
					s_d.txamp_ctl = reg_wdata;
				end
				OFF_STRAP_WAKE:
				begin
					s_d.strap_wake = reg_wdata & STRAP_WAKE_WMSK;
				end
				OFF_IRQ_MASK:
				begin
					s_d.irq_mask = reg_wdata[IRQ_W-1:0];
				end
				default:
				begin
					s_d.irq_mask = s_q.irq_mask;
				end
			endcase
		end

		// interrupt status and level output
		s_d.irq_stat = stat_next;
		s_d.irq = |(stat_next & s_d.irq_mask);

		// override forces address 0 to be non-broadcast
		s_d.bcast_off = s_d.strap_wake[BCAST_OVR_BIT] | broadcast_strap;

		// address match is registered, one cycle behind the valid strobe
		s_d.hit = 1'b0;
		if (mgmt_addr_valid)
		begin
			s_d.hit = (mgmt_addr == own_phy_addr) ||
				(mgmt_addr == 5'h00 && !s_q.bcast_off);
		end

		// read data stand only in the cycle after the strobe
		s_d.rdata = RDATA_NONE;
		if (reg_rd)
		begin
			case (reg_addr)
				OFF_OSC_CTL:
				begin
					s_d.rdata = s_q.osc_ctl;
				end
				OFF_TXAMP_CTL:
				begin
					s_d.rdata = s_q.txamp_ctl;
				end
				OFF_SYMERR_CNT:
				begin
					s_d.rdata = err_count;
				end
				OFF_STRAP_WAKE:
				begin
					s_d.rdata = s_q.strap_wake & STRAP_WAKE_WMSK;
				end
				OFF_IRQ_STATUS:
				begin
					s_d.rdata = {14'h0000, s_q.irq_stat};
				end
				OFF_IRQ_MASK:
				begin
					s_d.rdata = {14'h0000, s_q.irq_mask};
				end
				default:
				begin
					s_d.rdata = RDATA_NONE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------

	// wake enable resets to zero and is loaded from the strap afterwards
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s_q.phase      <= PH_LOAD;
			s_q.osc_ctl    <= RST_OSC_CTL;
			s_q.txamp_ctl  <= RST_TXAMP_CTL;
			s_q.strap_wake <= RST_STRAP_WAKE;
			s_q.irq_stat   <= RST_IRQ;
			s_q.irq_mask   <= RST_IRQ;
			s_q.irq        <= 1'b0;
			s_q.rdata      <= RDATA_NONE;
			s_q.hit        <= 1'b0;
			s_q.bcast_off  <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// wake pins
	// ------------------------------------------------------------

	// pins follow the sticky wake bit so software ends the request by clearing it
	pvc_wake_route u_wake (
		.clk_sys (clk_sys),
		.rst     (rst),
		.enable  (s_q.strap_wake[WAKE_EN_BIT]),
		.route   (wake_route),
		.pending (s_q.irq_stat[IRQ_WAKE_BIT]),
		.pin_a   (wake_pin_a),
		.pin_b   (wake_pin_b)
	);

	// ------------------------------------------------------------
	// outputs, all straight from state flops
	// ------------------------------------------------------------
	assign reg_rdata           = s_q.rdata;
	assign irq                 = s_q.irq;
	assign mgmt_addr_hit       = s_q.hit;
	assign broadcast_disable   = s_q.bcast_off;
	// one bit drives both the clock switch and the analog power-down
	assign slow_osc_select     = s_q.osc_ctl[OSC_SLOW_BIT];
	assign analog_frontend_pdn = s_q.osc_ctl[OSC_SLOW_BIT];
	// zero gives full amplitude; the paired extended bit is software's job
	assign tx_reduced_amp      = s_q.txamp_ctl[TX_REDUCED_BIT];

endmodule : pvc_regs

// File: verification/pvc_regs_properties.sv
// pvc_regs_properties: port-level concurrent checks of the vendor register block
module pvc_regs_properties
	import pvc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_rdata,
	input  wire logic [4:0]  own_phy_addr,
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic        mgmt_addr_valid,
	input  wire logic        mgmt_addr_hit,
	input  wire logic        broadcast_disable,
	input  wire logic        slow_osc_select,
	input  wire logic        analog_frontend_pdn,
	input  wire logic        tx_reduced_amp,
	input  wire logic [1:0]  wake_route,
	input  wire logic        wake_pin_a,
	input  wire logic        wake_pin_b,
	input  wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// register side effects
	// ------------------------------------------------------------
	osc_pdn_tie_a: assert property (slow_osc_select == analog_frontend_pdn)
		else $error("analog power-down differs from slow oscillator select");
	osc_write_a: assert property (reg_wr && reg_addr == OFF_OSC_CTL
		|=> slow_osc_select == $past(reg_wdata[OSC_SLOW_BIT])) else $error("osc select wrong");
	txamp_write_a: assert property (reg_wr && reg_addr == OFF_TXAMP_CTL
		|=> tx_reduced_amp == $past(reg_wdata[TX_REDUCED_BIT])) else $error("amplitude wrong");
	strap_ro_a: assert property (reg_rd && reg_addr == OFF_STRAP_WAKE
		|=> !reg_rdata[STRAP_RO_BIT]) else $error("reserved bit read as one");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == RDATA_NONE)
		else $error("read data outside read cycle");
	// irq is registered from the new mask, so a mask write shows one edge later; the check waits two
	irq_mask_a: assert property (reg_wr && reg_addr == OFF_IRQ_MASK
		&& reg_wdata[1:0] == 2'h0 |-> ##2 !irq) else $error("irq stays after mask off");

	// ------------------------------------------------------------
	// address match and wake pins
	// ------------------------------------------------------------
	own_hit_a: assert property (mgmt_addr_valid && mgmt_addr == own_phy_addr
		|=> mgmt_addr_hit) else $error("own address missed");
	bcast_off_a: assert property (mgmt_addr_valid && mgmt_addr == 5'h00
		&& own_phy_addr != 5'h00 && broadcast_disable && !$past(reg_wr)
		|=> !mgmt_addr_hit) else $error("address zero taken while broadcast off");
	bcast_on_a: assert property (mgmt_addr_valid && mgmt_addr == 5'h00
		&& !broadcast_disable && !$past(reg_wr) |=> mgmt_addr_hit) else $error("broadcast missed");
	hit_pulse_a: assert property (mgmt_addr_hit |-> $past(mgmt_addr_valid))
		else $error("hit without valid address");
	wake_route_a: assert property ($stable(wake_route) |-> !(wake_pin_a && wake_route[0])
		&& !(wake_pin_b && wake_route[1] == wake_route[0])) else $error("wake pin off route");

	cover property (mgmt_addr_hit);
	cover property ($rose(irq));
	cover property (wake_pin_a && wake_pin_b);
endmodule : pvc_regs_properties

// File: verification/pvc_mgmt_partner.sv
// pvc_mgmt_partner: management bus station presenting addresses to the block
module pvc_mgmt_partner
(
	input  wire logic        clk_sys,
	input  wire logic        send,
	input  wire logic [4:0]  send_addr,
	output logic [4:0]       mgmt_addr = 5'h1f,
	output logic             mgmt_addr_valid = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// address is qualified for one cycle; between frames it toggles so a stale value never hits
	always_ff @(posedge clk_sys)
	begin
		mgmt_addr_valid <= send;
		mgmt_addr       <= send ? send_addr : ~mgmt_addr;
	end
endmodule : pvc_mgmt_partner

// File: verification/pvc_regs_tb_top.sv
// pvc_regs_tb_top: randomised self-checking bench of the vendor register block
module pvc_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pvc_pkg::*;

	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  reg_addr, send_addr, mgmt_addr, own_phy_addr;
	logic [15:0] reg_wdata, reg_rdata, w, exp_cnt;
	logic [1:0]  wake_route;
	logic        reg_wr, reg_rd, rx_symbol_error, rx_frame_end, power_wake_event, send;
	logic        wake_enable_strap, broadcast_strap, mgmt_addr_valid, mgmt_addr_hit;
	logic        broadcast_disable, slow_osc_select, analog_frontend_pdn, tx_reduced_amp;
	logic        wake_pin_a, wake_pin_b, irq;
	logic [31:0] seed;
	int          miscompares = 0;
	int          total_checks = 0;

	pvc_regs uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_symbol_error(rx_symbol_error), .rx_frame_end(rx_frame_end),
		.power_wake_event(power_wake_event), .wake_route(wake_route),
		.wake_enable_strap(wake_enable_strap), .broadcast_strap(broadcast_strap),
		.own_phy_addr(own_phy_addr), .mgmt_addr(mgmt_addr), .mgmt_addr_valid(mgmt_addr_valid),
		.mgmt_addr_hit(mgmt_addr_hit), .broadcast_disable(broadcast_disable),
		.slow_osc_select(slow_osc_select), .analog_frontend_pdn(analog_frontend_pdn),
		.tx_reduced_amp(tx_reduced_amp), .wake_pin_a(wake_pin_a), .wake_pin_b(wake_pin_b),
		.irq(irq));
	pvc_mgmt_partner station (.clk_sys(clk_sys), .send(send), .send_addr(send_addr),
		.mgmt_addr(mgmt_addr), .mgmt_addr_valid(mgmt_addr_valid));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
	endfunction : lfsr
	task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk_word
	task automatic chk_bit(input string n, input logic e, input logic g);
		chk_word(n, {15'h0000, e}, {15'h0000, g});
	endtask : chk_bit
	// strobes drop at the sampling edge; the negedge leaves outputs settled
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(negedge clk_sys);
	endtask : wr
	task automatic rc(input logic [4:0] a, input logic [15:0] e, input string n);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk_word(n, e, reg_rdata);
	endtask : rc
	task automatic ma(input logic [4:0] a, input logic e);
		@(posedge clk_sys);
		send      <= 1'b1;
		send_addr <= a;
		@(posedge clk_sys);
		send <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk_bit("hit", e, mgmt_addr_hit);
	endtask : ma
	task automatic print_verdict();
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// ------------------------------------------------------------
	// clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial
	begin
		forever #50 clk_sys = ~clk_sys;
	end
	// the saturation run alone needs some 65.5k cycles
	initial
	begin
		repeat (90000) @(posedge clk_sys);
		miscompares++;
		print_verdict();
	end
	initial
	begin
		{reg_wr, reg_rd, rx_symbol_error, rx_frame_end, power_wake_event, send} = '0;
		{reg_addr, send_addr, reg_wdata, wake_route} = '0;
		own_phy_addr = 5'h05;
		wake_enable_strap = 1'b1;
		broadcast_strap = 1'b0;
		seed = 32'h268179fe;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		rc(OFF_OSC_CTL, RST_OSC_CTL, "osc");
		rc(OFF_TXAMP_CTL, RST_TXAMP_CTL, "amp");
		rc(OFF_STRAP_WAKE, 16'h8000, "strap");
		wr(OFF_SYMERR_CNT, 16'h1234);
		rc(OFF_SYMERR_CNT, RST_SYMERR_CNT, "cnt");
		wr(5'h02, 16'hffff);
		rc(5'h02, RDATA_NONE, "unmapped");
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			w = {seed[15:6], i[0], i[0], seed[3:0]};
			wr(OFF_OSC_CTL, w);
			chk_bit("slow", i[0], slow_osc_select);
			chk_bit("pdn", i[0], analog_frontend_pdn);
			rc(OFF_OSC_CTL, w, "osc");
			// the paired extended amplitude bit and its indirect access sit outside this block
			wr(OFF_TXAMP_CTL, w);
			chk_bit("amp", i[0], tx_reduced_amp);
			rc(OFF_TXAMP_CTL, w, "amp");
			wr(OFF_STRAP_WAKE, w | 16'h0400);
			rc(OFF_STRAP_WAKE, (w | 16'h0400) & STRAP_WAKE_WMSK, "strap");
		end
		// address zero: broadcast, then refused under override and under strap
		wr(OFF_STRAP_WAKE, 16'h0000);
		ma(5'h05, 1'b1);
		ma(5'h00, 1'b1);
		ma(5'h07, 1'b0);
		wr(OFF_STRAP_WAKE, 16'h0200);
		ma(5'h00, 1'b0);
		ma(5'h05, 1'b1);
		// address zero still answers when it is the own address
		@(posedge clk_sys);
		own_phy_addr <= 5'h00;
		ma(5'h00, 1'b1);
		@(posedge clk_sys);
		own_phy_addr <= 5'h05;
		wr(OFF_STRAP_WAKE, 16'h0000);
		@(posedge clk_sys);
		broadcast_strap <= 1'b1;
		ma(5'h00, 1'b0);
		chk_bit("bdis", 1'b1, broadcast_disable);
		@(posedge clk_sys);
		broadcast_strap <= 1'b0;
		// frames with errors before and at the frame end count once
		wr(OFF_IRQ_MASK, 16'h0001);
		exp_cnt = 16'h0000;
		for (int i = 0; i < 40; i++)
		begin
			seed = lfsr(seed);
			@(posedge clk_sys);
			rx_symbol_error <= seed[0] | (i == 0);
			rx_frame_end    <= 1'b0;
			@(posedge clk_sys);
			rx_symbol_error <= seed[1];
			rx_frame_end    <= 1'b1;
			exp_cnt += {15'h0000, seed[0] | seed[1] | (i == 0)};
		end
		@(posedge clk_sys);
		rx_frame_end    <= 1'b0;
		rx_symbol_error <= 1'b0;
		@(negedge clk_sys);
		chk_bit("irq", 1'b1, irq);
		rc(OFF_IRQ_STATUS, 16'h0001, "stat");
		rc(OFF_SYMERR_CNT, exp_cnt, "cnt");
		rc(OFF_SYMERR_CNT, 16'h0000, "cnt");
		wr(OFF_IRQ_STATUS, 16'h0001);
		repeat (2) @(negedge clk_sys);
		chk_bit("irq", 1'b0, irq);
		@(posedge clk_sys);
		rx_symbol_error <= 1'b1;
		rx_frame_end    <= 1'b1;
		repeat (65540) @(posedge clk_sys);
		rx_frame_end    <= 1'b0;
		rx_symbol_error <= 1'b0;
		rc(OFF_SYMERR_CNT, SYMERR_MAX, "sat");
		// wake routing over every code, then gated off
		wr(OFF_IRQ_MASK, 16'h0002);
		wr(OFF_IRQ_STATUS, 16'h0003);
		wr(OFF_STRAP_WAKE, 16'h8000);
		for (int r = 0; r < 5; r++)
		begin
			if (r == 4)
				wr(OFF_STRAP_WAKE, 16'h0000);
			@(posedge clk_sys);
			wake_route       <= (r == 4) ? 2'h2 : r[1:0];
			power_wake_event <= 1'b1;
			@(posedge clk_sys);
			power_wake_event <= 1'b0;
			repeat (2) @(negedge clk_sys);
			chk_bit("pina", r == 0 || r == 2, wake_pin_a);
			chk_bit("pinb", r == 1 || r == 2, wake_pin_b);
			chk_bit("irq", 1'b1, irq);
			wr(OFF_IRQ_STATUS, 16'h0002);
			repeat (2) @(negedge clk_sys);
			chk_bit("pins", 1'b0, wake_pin_a | wake_pin_b);
		end
		wr(OFF_IRQ_MASK, 16'h0000);
		// second reset with the wake strap low
		@(posedge clk_sys);
		wake_enable_strap <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rc(OFF_STRAP_WAKE, 16'h0000, "strap");
		print_verdict();
	end
endmodule : pvc_regs_tb_top

bind pvc_regs pvc_regs_properties chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.own_phy_addr(own_phy_addr), .mgmt_addr(mgmt_addr), .mgmt_addr_valid(mgmt_addr_valid),
	.mgmt_addr_hit(mgmt_addr_hit), .broadcast_disable(broadcast_disable),
	.slow_osc_select(slow_osc_select), .analog_frontend_pdn(analog_frontend_pdn),
	.tx_reduced_amp(tx_reduced_amp), .wake_route(wake_route), .wake_pin_a(wake_pin_a),
	.wake_pin_b(wake_pin_b), .irq(irq));
